/* scsp_consts.vh */
// command and status codes of the serial control and status port
`ifndef SCSP_CONSTS_VH
`define SCSP_CONSTS_VH

`define SCSP_BYTE_BITS         4'h8
`define SCSP_NULL_CMD          8'hff
`define SCSP_CMD_POWER_UP      8'h20
`define SCSP_CMD_POWER_DOWN    8'h21
`define SCSP_CMD_D_REQUEST_CLASS1         8'h0e
`define SCSP_CMD_D_REQUEST_CLASS2         8'h0f
`define SCSP_CMD_DACC_ON       8'h90
`define SCSP_CMD_DACC_OFF      8'h91
`define SCSP_CMD_ECHO_ZERO     8'h96
`define SCSP_CMD_ECHO_INV      8'h97
`define SCSP_CMD_ECHO_NORM     8'h9c
`define SCSP_CMD_EOM_ON        8'h10
`define SCSP_CMD_EOM_OFF       8'h11
`define SCSP_CMD_MAINT1_ON     8'h12
`define SCSP_CMD_MAINT1_OFF    8'h13
`define SCSP_CMD_TICK5_ON      8'h22
`define SCSP_CMD_TICK5_OFF     8'h23
`define SCSP_CMD_TICK30_ON     8'h24
`define SCSP_CMD_TICK30_OFF    8'h25
`define SCSP_CMD_MAINT2_ON     8'h26
`define SCSP_CMD_MAINT2_OFF    8'h27
`define SCSP_CMD_CHECK_ON      8'h28
`define SCSP_CMD_CHECK_OFF     8'h29
`define SCSP_CMD_BEAR1_ON      8'h14
`define SCSP_CMD_BEAR1_OFF     8'h15
`define SCSP_CMD_BEAR2_ON      8'h16
`define SCSP_CMD_BEAR2_OFF     8'h17
`define SCSP_CMD_LOOP_B1_LINE  8'h18
`define SCSP_CMD_LOOP_B2_LINE  8'h19
`define SCSP_CMD_LOOP_ALL_HOST 8'h1a
`define SCSP_CMD_LOOP_CLEAR    8'h1b
`define SCSP_CMD_LOOP_B1_HOST  8'h1c
`define SCSP_CMD_LOOP_B2_HOST  8'h1d
`define SCSP_CMD_STATE_ON      8'ha0
`define SCSP_CMD_STATE_OFF     8'ha1
`define SCSP_CMD_EXTRA_ON      8'ha2
`define SCSP_CMD_EXTRA_OFF     8'ha3
`define SCSP_CMD_INV_B1        8'ha4
`define SCSP_CMD_INV_B2        8'ha5
`define SCSP_CMD_NORM_POL      8'ha6
// message-load groups match on the upper nibble
`define SCSP_GRP_MT1_LOW       4'h3
`define SCSP_GRP_MT1_HIGH      4'h4
`define SCSP_GRP_MT2           4'h5
// pin redefinition matches on bits 7..3
`define SCSP_GRP_PIN_REDEFINE        5'h17

// loopback selector values
`define SCSP_LOOP_NONE         3'h0
`define SCSP_LOOP_B1_LINE      3'h1
`define SCSP_LOOP_B2_LINE      3'h2
`define SCSP_LOOP_ALL_HOST     3'h3
`define SCSP_LOOP_B1_HOST      3'h4
`define SCSP_LOOP_B2_HOST      3'h5
// echo modes
`define SCSP_ECHO_NORMAL       2'h0
`define SCSP_ECHO_ZERO         2'h1
`define SCSP_ECHO_INVERT       2'h2

// status codes
`define SCSP_ST_NO_CHANGE      8'h00
`define SCSP_ST_WAKE           8'h02
`define SCSP_ST_PENDING        8'h03
`define SCSP_ST_TICK           8'h04
`define SCSP_ST_RX_ERR         8'h05
`define SCSP_ST_EOM            8'h06
`define SCSP_ST_CONTENTION     8'h07
`define SCSP_ST_SLIP_BASE      8'h08
`define SCSP_ST_ACTIVATED      8'h0c
`define SCSP_ST_FRAME_LOSS     8'h0e
`define SCSP_ST_DEACTIVATED    8'h0f
`define SCSP_ST_MAINT1_HI      4'h3
`define SCSP_ST_MAINT2_HI      4'h5

// event source indices
`define SCSP_EV_WAKE           4'h0
`define SCSP_EV_PENDING        4'h1
`define SCSP_EV_ACTIVATED      4'h2
`define SCSP_EV_FRAME_LOSS     4'h3
`define SCSP_EV_DEACTIVATED    4'h4
`define SCSP_EV_EOM            4'h5
`define SCSP_EV_CONTENTION     4'h6
`define SCSP_EV_MAINT1         4'h7
`define SCSP_EV_MAINT2         4'h8
`define SCSP_EV_TICK           4'h9
`define SCSP_EV_RX_ERR         4'ha
`define SCSP_EV_SLIP           4'hb
`define SCSP_EV_COUNT          12

// multiframes per long tick
`define SCSP_TICK30_DIV        3'h6

`endif

/* scsp_sync2.v */
// two-stage synchroniser for pins from outside the clock domain
module scsp_sync2 #(
	parameter W = 1
) (
	// clock and reset
	input  wire         clk,
	input  wire         rst_n,
	// data
	input  wire [W-1:0] d,
	output reg  [W-1:0] q
);

	reg [W-1:0] stage1;

	always @(posedge clk) begin
		if (!rst_n) begin
			stage1 <= {W{1'b1}};
			q      <= {W{1'b1}};
		end else begin
			stage1 <= d;
			q      <= stage1;
		end
	end

endmodule // scsp_sync2

/* scsp_event_rr.v */
// per-source event latches with round-robin selection
module scsp_event_rr #(
	parameter N  = 12,
	parameter PW = 4
) (
	// clock and reset
	input  wire          clk,
	input  wire          rst_n,
	// latch control
	input  wire [N-1:0]  setVec,
	input  wire [N-1:0]  clrVec,
	input  wire          take,
	// selection
	output reg  [N-1:0]  pending,
	output reg           anyPending,
	output reg  [PW-1:0] sel
);

	reg     [PW-1:0] ptr;
	reg     [N-1:0]  takeMask;
	reg     [N-1:0]  next_pending;
	reg              found;
	integer          i;
	integer          idx;

	// first pending source at or after the pointer, wrapping round
	always @* begin
		sel   = {PW{1'b0}};
		found = 1'b0;
		idx   = 0;
		for (i = 0; i < N; i = i + 1) begin
			idx = (ptr + i) % N;
			if (!found && pending[idx]) begin
				found = 1'b1;
				sel   = idx[PW-1:0];
			end
		end
		anyPending   = |pending;
		takeMask     = take ? ({{(N-1){1'b0}}, 1'b1} << sel) : {N{1'b0}};
		// a new event wins over any clear in the same cycle
		next_pending = (pending & ~clrVec & ~takeMask) | setVec;
	end

	always @(posedge clk) begin
		if (!rst_n) begin
			pending <= {N{1'b0}};
			ptr     <= {PW{1'b0}};
		end else begin
			pending <= next_pending;
			if (take && anyPending)
				ptr <= (sel == N - 1) ? {PW{1'b0}} : sel + 1'b1;
		end
	end

endmodule // scsp_event_rr

/* scsp_port.v */
// serial control and status port: command shift, status shift, alert
module scsp_port (
	// clock and reset
	input  wire       ref_clk,
	input  wire       rst_n,
	// serial port pins
	input  wire       portShiftClock,
	input  wire       portSelectN,
	input  wire       serialCmdIn,
	output reg        statusShiftOut,
	output reg        statusOutEnN,
	output wire       alertOutN,
	output reg        alertOutEnN,
	// device events, one-cycle pulses on ref_clk
	input  wire       apEvent,
	input  wire       activatedEvent,
	input  wire       frameLossEvent,
	input  wire       deactivatedEvent,
	input  wire       eomEvent,
	input  wire       contentionEvent,
	input  wire       maintRx1Event,
	input  wire [3:0] maintRx1Msg,
	input  wire       maintRx2Event,
	input  wire [3:0] maintRx2Msg,
	input  wire       multiframeTick,
	input  wire       rxFrameErrorEvent,
	input  wire       slipTxEvent,
	input  wire       slipRxEvent,
	input  wire       lineActivity,
	// device state and mode
	input  wire [2:0] deviceState,
	input  wire       terminalMasterMode,
	// decoded controls
	output reg        poweredUp,
	output reg        dRequestClass1,
	output reg        dRequestClass2,
	output reg        dAccessEn,
	output reg  [1:0] echoMode,
	output reg        bearer1En,
	output reg        bearer2En,
	output reg        invertBearer1,
	output reg        invertBearer2,
	output reg  [2:0] loopSelect,
	output reg        rxCheckEn,
	output reg  [3:0] maintTxMsg,
	output reg        maint1TxLowLoad,
	output reg        maint1TxHighLoad,
	output reg        maint2TxLoad,
	output reg  [2:0] pinSelect,
	output reg        pinSelectLoad
);

`include "scsp_consts.vh"

	localparam PW = 4;
	localparam N  = `SCSP_EV_COUNT;

	////////////////////////////////////////////////////////////////////
	// pin synchronisation and edge detection

	wire [2:0] pinSync;
	reg        clkPrev;
	reg        selPrev;
	reg        lsdArmed;

	scsp_sync2 #(
		.W (3)
	) u_sync (
		.clk   (ref_clk),
		.rst_n (rst_n),
		.d     ({portShiftClock, portSelectN, serialCmdIn}),
		.q     (pinSync)
	);

	wire sclk     = pinSync[2];
	wire selN     = pinSync[1];
	wire cmdBit   = pinSync[0];
	wire sclkRise = sclk & ~clkPrev;
	wire sclkFall = ~sclk & clkPrev;
	wire selFall  = ~selN & selPrev;
	wire selRise  = selN & ~selPrev;

	always @(posedge ref_clk) begin
		if (!rst_n) begin
			clkPrev <= 1'b1;
			selPrev <= 1'b1;
		end else begin
			clkPrev <= sclk;
			selPrev <= selN;
		end
	end

	////////////////////////////////////////////////////////////////////
	// event latches and round-robin report selection

	reg        eomIrqEn;
	reg        maint1En;
	reg        maint2En;
	reg        tick5En;
	reg        tick30En;
	reg        extraEventsEn;
	reg        stateReportEn;
	reg  [2:0] tickDiv;
	reg  [3:0] maint1Data;
	reg  [3:0] maint2Data;
	reg  [1:0] slipData;
	reg        take;
	reg  [7:0] reportByte;
	reg  [N-1:0] setVec;
	reg  [N-1:0] clrVec;
	wire [N-1:0] pending;
	wire       anyPending;
	wire [PW-1:0] sel;
	reg        cmdPowerUp;
	reg        cmdPowerDown;

	wire tick30 = multiframeTick && (tickDiv == `SCSP_TICK30_DIV - 3'h1);
	wire lsdHit = lsdArmed && !poweredUp && lineActivity;

	always @* begin
		setVec = {N{1'b0}};
		clrVec = {N{1'b0}};
		setVec[`SCSP_EV_WAKE]        = lsdHit;
		setVec[`SCSP_EV_PENDING]     = apEvent;
		setVec[`SCSP_EV_ACTIVATED]   = activatedEvent;
		setVec[`SCSP_EV_FRAME_LOSS]  = frameLossEvent;
		setVec[`SCSP_EV_DEACTIVATED] = deactivatedEvent;
		setVec[`SCSP_EV_EOM]         = eomEvent && eomIrqEn;
		setVec[`SCSP_EV_CONTENTION]  = contentionEvent;
		setVec[`SCSP_EV_MAINT1]      = maintRx1Event && maint1En;
		setVec[`SCSP_EV_MAINT2]      = maintRx2Event && maint2En;
		setVec[`SCSP_EV_TICK]        = (multiframeTick && tick5En) || (tick30 && tick30En);
		setVec[`SCSP_EV_RX_ERR]      = rxFrameErrorEvent && extraEventsEn;
		setVec[`SCSP_EV_SLIP]        = (slipTxEvent || slipRxEvent) && extraEventsEn;
		// deactivation flushes every other report
		if (deactivatedEvent) begin
			clrVec = {N{1'b1}};
			clrVec[`SCSP_EV_DEACTIVATED] = 1'b0;
		end
		// power commands clear the wake report
		if (cmdPowerUp || cmdPowerDown)
			clrVec[`SCSP_EV_WAKE] = 1'b1;
	end

	scsp_event_rr #(
		.N  (N),
		.PW (PW)
	) u_events (
		.clk        (ref_clk),
		.rst_n      (rst_n),
		.setVec     (setVec),
		.clrVec     (clrVec),
		.take       (take),
		.pending    (pending),
		.anyPending (anyPending),
		.sel        (sel)
	);

	// status byte for the selected source
	always @* begin
		case (sel)
			`SCSP_EV_WAKE:        reportByte = `SCSP_ST_WAKE;
			`SCSP_EV_PENDING:     reportByte = `SCSP_ST_PENDING;
			`SCSP_EV_ACTIVATED:   reportByte = `SCSP_ST_ACTIVATED;
			`SCSP_EV_FRAME_LOSS:  reportByte = `SCSP_ST_FRAME_LOSS;
			`SCSP_EV_DEACTIVATED: reportByte = `SCSP_ST_DEACTIVATED;
			`SCSP_EV_EOM:         reportByte = `SCSP_ST_EOM;
			`SCSP_EV_CONTENTION:  reportByte = `SCSP_ST_CONTENTION;
			`SCSP_EV_MAINT1:      reportByte = {`SCSP_ST_MAINT1_HI, maint1Data};
			`SCSP_EV_MAINT2:      reportByte = {`SCSP_ST_MAINT2_HI, maint2Data};
			`SCSP_EV_TICK:        reportByte = `SCSP_ST_TICK;
			`SCSP_EV_RX_ERR:      reportByte = `SCSP_ST_RX_ERR;
			`SCSP_EV_SLIP:        reportByte = `SCSP_ST_SLIP_BASE | {6'h00, slipData};
			default:              reportByte = `SCSP_ST_NO_CHANGE;
		endcase
	end

	// event payloads: a later maintenance message overwrites the held value; slip bits accumulate while pending
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			maint1Data <= 4'h0;
			maint2Data <= 4'h0;
			slipData   <= 2'h0;
			tickDiv    <= 3'h0;
			lsdArmed   <= 1'b1;
		end else begin
			if (setVec[`SCSP_EV_MAINT1])
				maint1Data <= maintRx1Msg;
			if (setVec[`SCSP_EV_MAINT2])
				maint2Data <= maintRx2Msg;
			if (setVec[`SCSP_EV_SLIP])
				slipData <= {slipRxEvent, slipTxEvent} |
					(pending[`SCSP_EV_SLIP] ? slipData : 2'h0);
			else if (!pending[`SCSP_EV_SLIP])
				slipData <= 2'h0;
			if (multiframeTick)
				tickDiv <= tick30 ? 3'h0 : tickDiv + 3'h1;
			// one detect per power-down; power-up disarms, power-down re-arms
			if (cmdPowerUp)
				lsdArmed <= 1'b0;
			else if (cmdPowerDown)
				lsdArmed <= 1'b1;
			else if (lsdHit)
				lsdArmed <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// byte exchange and alert

	localparam ST_IDLE  = 1'b0;
	localparam ST_SHIFT = 1'b1;

	reg       state;
	reg [7:0] cmdShift;
	reg [7:0] outShift;
	reg [3:0] bitCount;
	reg       alertAct;
	reg       cmdValid;
	reg [7:0] cmdByte;

	assign alertOutN = 1'b0;

	// consume the report in the cycle that loads it, so a new event cannot move the selection
	always @* begin
		take = (state == ST_IDLE) && selFall && anyPending;
	end

	always @(posedge ref_clk) begin
		if (!rst_n) begin
			state          <= ST_IDLE;
			cmdShift       <= 8'h00;
			outShift       <= 8'h00;
			bitCount       <= 4'h0;
			alertAct       <= 1'b0;
			cmdValid       <= 1'b0;
			cmdByte        <= `SCSP_NULL_CMD;
			statusShiftOut <= 1'b0;
			statusOutEnN   <= 1'b1;
			alertOutEnN    <= 1'b1;
		end else begin
			cmdValid <= 1'b0;
			// alert may only assert while select is high
			if (!selN && sclkRise)
				alertAct <= 1'b0;
			else if (selN && state == ST_IDLE && anyPending)
				alertAct <= 1'b1;
			alertOutEnN <= ~alertAct;
			case (state)
				ST_IDLE: begin
					statusOutEnN <= 1'b1;
					if (selFall) begin
						// present the report, the device-state byte when enabled, or the no-change byte
						if (anyPending) begin
							outShift <= reportByte;
						end else if (stateReportEn) begin
							outShift <= {1'b1, deviceState, 4'h0};
						end else begin
							outShift <= `SCSP_ST_NO_CHANGE;
						end
						bitCount <= 4'h0;
						state    <= ST_SHIFT;
					end
				end
				ST_SHIFT: begin
					statusOutEnN   <= 1'b0;
					statusShiftOut <= outShift[7];
					if (selRise) begin
						// only a full byte is executed
						cmdValid <= (bitCount == `SCSP_BYTE_BITS);
						cmdByte  <= cmdShift;
						state    <= ST_IDLE;
						statusOutEnN <= 1'b1;
					end else begin
						if (sclkRise) begin
							cmdShift <= {cmdShift[6:0], cmdBit};
							if (bitCount != 4'hf)
								bitCount <= bitCount + 4'h1;
						end
						// first bit stands from select fall; shift on each fall after a rise
						if (sclkFall && bitCount != 4'h0)
							outShift <= {outShift[6:0], 1'b0};
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// command execution, works in either power state

	always @* begin
		cmdPowerUp   = cmdValid && cmdByte == `SCSP_CMD_POWER_UP;
		cmdPowerDown = cmdValid && cmdByte == `SCSP_CMD_POWER_DOWN;
	end

	always @(posedge ref_clk) begin
		if (!rst_n) begin
			poweredUp        <= 1'b0;
			dRequestClass1   <= 1'b0;
			dRequestClass2   <= 1'b0;
			dAccessEn        <= terminalMasterMode;
			echoMode         <= `SCSP_ECHO_NORMAL;
			eomIrqEn         <= 1'b1;
			maint1En         <= 1'b0;
			maint2En         <= 1'b0;
			tick5En          <= 1'b0;
			tick30En         <= 1'b0;
			rxCheckEn        <= 1'b0;
			extraEventsEn    <= 1'b0;
			stateReportEn    <= 1'b0;
			bearer1En        <= 1'b0;
			bearer2En        <= 1'b0;
			invertBearer1    <= 1'b0;
			invertBearer2    <= 1'b0;
			loopSelect       <= `SCSP_LOOP_NONE;
			maintTxMsg       <= 4'h0;
			maint1TxLowLoad  <= 1'b0;
			maint1TxHighLoad <= 1'b0;
			maint2TxLoad     <= 1'b0;
			pinSelect        <= 3'h0;
			pinSelectLoad    <= 1'b0;
		end else begin
			dRequestClass1   <= 1'b0;
			dRequestClass2   <= 1'b0;
			maint1TxLowLoad  <= 1'b0;
			maint1TxHighLoad <= 1'b0;
			maint2TxLoad     <= 1'b0;
			pinSelectLoad    <= 1'b0;
			if (cmdValid) begin
				case (cmdByte[7:4])
					`SCSP_GRP_MT1_LOW: begin
						maintTxMsg      <= cmdByte[3:0];
						maint1TxLowLoad <= 1'b1;
					end
					`SCSP_GRP_MT1_HIGH: begin
						maintTxMsg       <= cmdByte[3:0];
						maint1TxHighLoad <= 1'b1;
					end
					`SCSP_GRP_MT2: begin
						maintTxMsg   <= cmdByte[3:0];
						maint2TxLoad <= 1'b1;
					end
					default: begin
						if (cmdByte[7:3] == `SCSP_GRP_PIN_REDEFINE) begin
							pinSelect     <= cmdByte[2:0];
							pinSelectLoad <= 1'b1;
						end
					end
				endcase
				case (cmdByte)
					`SCSP_CMD_POWER_UP:      poweredUp      <= 1'b1;
					`SCSP_CMD_POWER_DOWN:    poweredUp      <= 1'b0;
					`SCSP_CMD_D_REQUEST_CLASS1:         dRequestClass1 <= 1'b1;
					`SCSP_CMD_D_REQUEST_CLASS2:         dRequestClass2 <= 1'b1;
					`SCSP_CMD_DACC_ON:       dAccessEn      <= 1'b1;
					`SCSP_CMD_DACC_OFF:      dAccessEn      <= 1'b0;
					`SCSP_CMD_ECHO_ZERO:     echoMode <= `SCSP_ECHO_ZERO;
					`SCSP_CMD_ECHO_INV:      echoMode <= `SCSP_ECHO_INVERT;
					`SCSP_CMD_ECHO_NORM:     echoMode <= `SCSP_ECHO_NORMAL;
					`SCSP_CMD_EOM_ON:        eomIrqEn <= 1'b1;
					`SCSP_CMD_EOM_OFF:       eomIrqEn <= 1'b0;
					`SCSP_CMD_MAINT1_ON:     maint1En <= 1'b1;
					`SCSP_CMD_MAINT1_OFF:    maint1En <= 1'b0;
					`SCSP_CMD_MAINT2_ON:     maint2En <= 1'b1;
					`SCSP_CMD_MAINT2_OFF:    maint2En <= 1'b0;
					`SCSP_CMD_TICK5_ON:      tick5En  <= 1'b1;
					`SCSP_CMD_TICK5_OFF:     tick5En  <= 1'b0;
					`SCSP_CMD_TICK30_ON:     tick30En <= 1'b1;
					`SCSP_CMD_TICK30_OFF:    tick30En <= 1'b0;
					`SCSP_CMD_CHECK_ON:      rxCheckEn <= 1'b1;
					`SCSP_CMD_CHECK_OFF:     rxCheckEn <= 1'b0;
					`SCSP_CMD_BEAR1_ON:      bearer1En <= 1'b1;
					`SCSP_CMD_BEAR1_OFF:     bearer1En <= 1'b0;
					`SCSP_CMD_BEAR2_ON:      bearer2En <= 1'b1;
					`SCSP_CMD_BEAR2_OFF:     bearer2En <= 1'b0;
					`SCSP_CMD_INV_B1:        invertBearer1 <= 1'b1;
					`SCSP_CMD_INV_B2:        invertBearer2 <= 1'b1;
					`SCSP_CMD_NORM_POL: begin
						invertBearer1 <= 1'b0;
						invertBearer2 <= 1'b0;
					end
					`SCSP_CMD_LOOP_B1_LINE:  loopSelect <= `SCSP_LOOP_B1_LINE;
					`SCSP_CMD_LOOP_B2_LINE:  loopSelect <= `SCSP_LOOP_B2_LINE;
					`SCSP_CMD_LOOP_ALL_HOST: loopSelect <= `SCSP_LOOP_ALL_HOST;
					`SCSP_CMD_LOOP_B1_HOST:  loopSelect <= `SCSP_LOOP_B1_HOST;
					`SCSP_CMD_LOOP_B2_HOST:  loopSelect <= `SCSP_LOOP_B2_HOST;
					`SCSP_CMD_LOOP_CLEAR:    loopSelect <= `SCSP_LOOP_NONE;
					`SCSP_CMD_EXTRA_ON:      extraEventsEn <= 1'b1;
					`SCSP_CMD_EXTRA_OFF:     extraEventsEn <= 1'b0;
					`SCSP_CMD_STATE_ON:      stateReportEn <= 1'b1;
					`SCSP_CMD_STATE_OFF:     stateReportEn <= 1'b0;
					default: ;
				endcase
			end
		end
	end

endmodule // scsp_port

/* scsp_checker.sv */
// assertions on the serial port pins and decoded outputs
module scsp_checker (
	// clock and reset
	input wire       ref_clk,
	input wire       rst_n,
	// serial pins
	input wire       portShiftClock,
	input wire       portSelectN,
	input wire       statusShiftOut,
	input wire       statusOutEnN,
	input wire       alertOutN,
	input wire       alertOutEnN,
	// decoded outputs
	input wire       dRequestClass1,
	input wire       maint1TxLowLoad,
	input wire       maint2TxLoad,
	input wire       pinSelectLoad,
	input wire       bearer1En,
	input wire [1:0] echoMode,
	input wire [2:0] loopSelect
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	logic [3:0] selHigh;
	wire        cmdPulse = dRequestClass1 | maint1TxLowLoad | maint2TxLoad | pinSelectLoad;
	////////////////////////////////////////////////////////////////
	// cycles since select was released, saturating
	always @(posedge ref_clk) begin
		if (!rst_n || !portSelectN)
			selHigh <= 4'h0;
		else if (selHigh != 4'hf)
			selHigh <= selHigh + 4'h1;
	end
	////////////////////////////////////////////////////////////////
	AST_ALERT_DATA: assert property (!alertOutN)
		else $error("alert data not low");
	AST_ALERT_SEL_HIGH: assert property ($fell(alertOutEnN) |-> portSelectN)
		else $error("alert raised with select low");
	AST_ALERT_HOLD: assert property (!alertOutEnN && selHigh > 4'h7 |=> !alertOutEnN)
		else $error("alert dropped without a read");
	AST_ALERT_FREE: assert property ($rose(portShiftClock) && !portSelectN && !alertOutEnN
		|-> ##[1:8] alertOutEnN)
		else $error("alert not released");
	AST_OUT_ON: assert property ($fell(portSelectN) |-> ##[2:6] !statusOutEnN)
		else $error("status output not enabled");
	AST_OUT_OFF: assert property (selHigh > 4'h7 |-> statusOutEnN)
		else $error("status output driven while idle");
	AST_BIT_EDGE: assert property (!statusOutEnN && !$past(statusOutEnN)
		&& !$stable(statusShiftOut) |-> !portShiftClock)
		else $error("status bit changed with clock high");
	AST_CMD_LATE: assert property (cmdPulse |-> portSelectN && $past(portSelectN, 2))
		else $error("command acted before select rise");
	AST_ONE_LOAD: assert property ($onehot0({dRequestClass1, maint1TxLowLoad,
		maint2TxLoad, pinSelectLoad}))
		else $error("two loads at once");
	AST_CTRL_HOLD: assert property (!$stable({bearer1En, echoMode, loopSelect})
		|-> portSelectN)
		else $error("control changed during a byte");
endmodule // scsp_checker

bind scsp_port scsp_checker scsp_checker_inst (
	.ref_clk, .rst_n, .portShiftClock, .portSelectN, .statusShiftOut,
	.statusOutEnN, .alertOutN, .alertOutEnN, .dRequestClass1, .maint1TxLowLoad,
	.maint2TxLoad, .pinSelectLoad, .bearer1En, .echoMode, .loopSelect
);

/* scsp_host_model.sv */
// host-side serial master driving the port pins
module scsp_host_model (
	// serial pins toward the port
	output logic portShiftClock,
	output logic portSelectN,
	output logic serialCmdIn,
	input  wire  statusShiftOut,
	input  wire  statusOutEnN
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		portShiftClock = 1'b0;
		portSelectN = 1'b1;
		serialCmdIn = 1'b1;
	end
	// one exchange; fewer than eight clocks gives an aborted byte
	task automatic xfer(input logic [7:0] c, input int n, output logic [7:0] st);
		st = 8'h00;
		portSelectN = 1'b0;
		#125;
		for (int i = 7; i > 7 - n; i--) begin
			serialCmdIn = c[i];
			#62.5;
			portShiftClock = 1'b1;
			st[i] = statusOutEnN ? 1'bx : statusShiftOut;
			#62.5;
			portShiftClock = 1'b0;
		end
		#62.5;
		portSelectN = 1'b1;
		// released data line must not look like a held bit
		serialCmdIn = ~serialCmdIn;
		#125;
	endtask
endmodule // scsp_host_model

/* tb_top.sv */
// self-checking bench for the serial control and status port
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic        ref_clk, rst_n, lineActivity, terminalMasterMode;
	logic [2:0]  deviceState;
	logic [11:0] evVec;
	logic [3:0]  msg1;
	logic [5:0]  seen;
	logic [7:0]  st;
	logic [15:0] rmask;
	int          err_total, checked, cycles, nTick;
	wire         portShiftClock, portSelectN, serialCmdIn, statusShiftOut, statusOutEnN;
	wire         alertOutN, alertOutEnN, poweredUp, dRequestClass1, dRequestClass2, dAccessEn;
	wire         bearer1En, bearer2En, invertBearer1, invertBearer2, rxCheckEn, pinSelectLoad;
	wire         maint1TxLowLoad, maint1TxHighLoad, maint2TxLoad;
	wire [1:0]   echoMode;
	wire [2:0]   loopSelect, pinSelect;
	wire [3:0]   maintTxMsg;
	// open-drain alert with pull-up
	wire         alertPin = alertOutEnN ? 1'b1 : alertOutN;
	wire [11:0]  lv = {poweredUp, dAccessEn, echoMode, bearer1En, bearer2En, invertBearer1,
		invertBearer2, loopSelect, rxCheckEn};
	wire [12:0]  pv = {seen, maintTxMsg, pinSelect};
	scsp_port scsp_port_inst (.ref_clk, .rst_n, .portShiftClock, .portSelectN, .serialCmdIn,
		.statusShiftOut, .statusOutEnN, .alertOutN, .alertOutEnN, .apEvent(evVec[1]),
		.activatedEvent(evVec[2]), .frameLossEvent(evVec[3]), .deactivatedEvent(evVec[4]),
		.eomEvent(evVec[5]), .contentionEvent(evVec[6]), .maintRx1Event(evVec[7]),
		.maintRx1Msg(msg1), .maintRx2Event(evVec[8]), .maintRx2Msg(msg1),
		.multiframeTick(evVec[9]), .rxFrameErrorEvent(evVec[10]), .slipTxEvent(evVec[11]),
		.slipRxEvent(evVec[0]), .lineActivity, .deviceState, .terminalMasterMode,
		.poweredUp, .dRequestClass1, .dRequestClass2, .dAccessEn, .echoMode, .bearer1En,
		.bearer2En, .invertBearer1, .invertBearer2, .loopSelect, .rxCheckEn, .maintTxMsg,
		.maint1TxLowLoad, .maint1TxHighLoad, .maint2TxLoad, .pinSelect, .pinSelectLoad);
	scsp_host_model scsp_host_model_inst (.portShiftClock, .portSelectN, .serialCmdIn,
		.statusShiftOut, .statusOutEnN);
	////////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		seen <= seen | {dRequestClass1, dRequestClass2, maint1TxLowLoad, maint1TxHighLoad,
			maint2TxLoad, pinSelectLoad};
		cycles = cycles + 1;
		if (cycles == 40000) begin
			err_total = err_total + 1;
			finish_test();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic rd(input logic [7:0] e);
		scsp_host_model_inst.xfer(8'hff, 8, st);
		check(16'(st), 16'(e));
	endtask
	task automatic cmd(input logic [7:0] c);
		@(negedge ref_clk);
		seen = 6'h00;
		scsp_host_model_inst.xfer(c, 8, st);
	endtask
	task automatic lvl(input logic [7:0] c, input logic [11:0] e);
		cmd(c);
		check(16'(lv), 16'(e));
	endtask
	task automatic pul(input logic [7:0] c, input logic [12:0] e);
		cmd(c);
		check(16'(pv), 16'(e));
	endtask
	task automatic ev(input logic [11:0] m, input logic [3:0] mg);
		@(negedge ref_clk);
		evVec = m;
		msg1 = mg;
		@(negedge ref_clk);
		evVec = 12'h000;
		repeat (6) @(negedge ref_clk);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		rst_n = 1'b0;
		lineActivity = 1'b0;
		deviceState = 3'h5;
		terminalMasterMode = 1'b0;
		evVec = 12'h000;
		msg1 = 4'h0;
		seen = 6'h00;
		err_total = 0;
		checked = 0;
		cycles = 0;
		repeat (4) @(negedge ref_clk);
		rst_n = 1'b1;
		repeat (4) @(negedge ref_clk);
		lineActivity = 1'b1;
		repeat (6) @(negedge ref_clk);
		check(16'(alertPin), 16'h0000);
		rd(8'h02);
		rd(8'h00);
		check(16'(alertPin), 16'h0001);
		lvl(8'h20, 12'h800);
		lineActivity = 1'b0;
		lvl(8'h90, 12'hc00);
		lvl(8'h91, 12'h800);
		lvl(8'h96, 12'h900);
		lvl(8'h97, 12'ha00);
		lvl(8'h9c, 12'h800);
		lvl(8'h14, 12'h880);
		lvl(8'h16, 12'h8c0);
		lvl(8'ha4, 12'h8e0);
		lvl(8'ha5, 12'h8f0);
		lvl(8'ha6, 12'h8c0);
		lvl(8'h15, 12'h840);
		lvl(8'h17, 12'h800);
		lvl(8'h18, 12'h802);
		lvl(8'h19, 12'h804);
		lvl(8'h1a, 12'h806);
		lvl(8'h1c, 12'h808);
		lvl(8'h1d, 12'h80a);
		lvl(8'h1b, 12'h800);
		lvl(8'h28, 12'h801);
		lvl(8'h29, 12'h800);
		lvl(8'h01, 12'h800);
		lvl(8'h21, 12'h000);
		scsp_host_model_inst.xfer(8'h14, 7, st);
		check(16'(lv), 16'h0000);
		lineActivity = 1'b1;
		repeat (6) @(negedge ref_clk);
		rd(8'h02);
		lvl(8'h20, 12'h800);
		pul(8'h0e, 13'h1000);
		pul(8'h0f, 13'h0800);
		pul(8'h3a, 13'h0450);
		pul(8'h45, 13'h0228);
		pul(8'h5c, 13'h0160);
		pul(8'hbb, 13'h00e3);
		ev(12'h06a, 4'h0);
		rmask = 16'h0000;
		for (int k = 0; k < 4; k++) begin
			check(16'(alertPin), 16'h0000);
			scsp_host_model_inst.xfer(8'hff, 8, st);
			rmask = rmask | (16'h0001 << st[3:0]);
		end
		check(rmask, 16'h40c8);
		rd(8'h00);
		cmd(8'h11);
		ev(12'h020, 4'h0);
		rd(8'h00);
		cmd(8'h10);
		ev(12'h020, 4'h0);
		rd(8'h06);
		ev(12'h080, 4'h3);
		rd(8'h00);
		cmd(8'h12);
		ev(12'h080, 4'h3);
		ev(12'h080, 4'h9);
		rd(8'h39);
		cmd(8'h26);
		ev(12'h100, 4'h6);
		rd(8'h56);
		cmd(8'h27);
		cmd(8'h13);
		ev(12'h180, 4'h6);
		rd(8'h00);
		ev(12'h024, 4'h0);
		ev(12'h010, 4'h0);
		rd(8'h0f);
		rd(8'h00);
		ev(12'h004, 4'h0);
		rd(8'h0c);
		ev(12'h400, 4'h0);
		rd(8'h00);
		cmd(8'ha2);
		ev(12'h801, 4'h0);
		rd(8'h0b);
		ev(12'h400, 4'h0);
		rd(8'h05);
		ev(12'h800, 4'h0);
		rd(8'h09);
		ev(12'h001, 4'h0);
		rd(8'h0a);
		cmd(8'ha3);
		ev(12'h400, 4'h0);
		rd(8'h00);
		cmd(8'h22);
		ev(12'h200, 4'h0);
		rd(8'h04);
		cmd(8'h23);
		cmd(8'h24);
		nTick = 0;
		for (int k = 0; k < 6; k++) begin
			ev(12'h200, 4'h0);
			scsp_host_model_inst.xfer(8'hff, 8, st);
			nTick = nTick + ((st == 8'h04) ? 1 : 0);
		end
		check(16'(nTick), 16'h0001);
		cmd(8'ha0);
		rd(8'hd0);
		cmd(8'ha1);
		rd(8'h00);
		// second reset in master mode: access defaults on, wake report again
		terminalMasterMode = 1'b1;
		@(negedge ref_clk);
		rst_n = 1'b0;
		repeat (4) @(negedge ref_clk);
		rst_n = 1'b1;
		repeat (3) @(negedge ref_clk);
		check(16'(lv), 16'h0400);
		repeat (6) @(negedge ref_clk);
		rd(8'h02);
		finish_test();
	end
endmodule // tb_top
